// [mem_map_regs.svh]
// Constants for the data and program memory address map
`ifndef MEM_MAP_REGS_SVH
`define MEM_MAP_REGS_SVH

// ==========================================
// Internal data space
`define UPPER_HALF_BASE   8'h80
`define BANK_AREA_TOP     8'h1F
`define BIT_AREA_BASE     8'h20
`define BIT_AREA_TOP      8'h2F
`define BANK_SIZE         8'h08

// ==========================================
// External data space
`define ONCHIP_SPLIT_TOP  16'h0FFF
`define ONCHIP_ADDR_MASK  16'h0FFF

// ==========================================
// Program space
`define PROG_RSVD_BASE    17'h0EE00
`define PROG_RSVD_TOP     17'h0FFFF
`define PROG_XSECT_BASE   17'h10000
`define PROG_XSECT_TOP    17'h1007F
`define SECTOR_MAIN_MASK  17'h1FE00
`define SECTOR_X_MASK     17'h1FF80

// ==========================================
// Reset values
`define PAGE_RESET        8'h00
`define BANK_RESET        2'h0

`endif

// [mem_map_pkg.sv]
// Types for the memory address map
package mem_map_pkg;

   // Target of an internal data access
   typedef enum logic [1:0]
   {
      TGT_RAM_LOW  = 2'b00,
      TGT_RAM_HIGH = 2'b01,
      TGT_SFS      = 2'b10
   } int_target_t;

   // External data mapping mode
   typedef enum logic [1:0]
   {
      XMAP_ONCHIP  = 2'b00,
      XMAP_SPLIT   = 2'b01,
      XMAP_OFFCHIP = 2'b10
   } xmap_mode_t;

endpackage

// [mem_map.sv]
// Data and program memory address decoder
`timescale 1ns/1ps
`include "mem_map_regs.svh"

module mem_map
(
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // Internal data request
   input  wire logic        int_req_in,
   input  wire logic        int_indirect_in,
   input  wire logic        int_bitmode_in,
   input  wire logic [7:0]  int_addr_in,
   input  wire logic        reg_req_in,
   input  wire logic [2:0]  reg_num_in,
   input  wire logic [1:0]  bank_sel_in,
   input  wire logic [7:0]  page_sel_in,
   // External data request
   input  wire logic        x_req_in,
   input  wire logic [15:0] x_addr_in,
   input  wire logic [1:0]  xmap_mode_in,
   input  wire logic        mux_mode_in,
   // Program request
   input  wire logic        prog_req_in,
   input  wire logic        prog_erase_in,
   input  wire logic [16:0] prog_addr_in,
   // Internal answers
   output logic             ram_sel_out,
   output logic [7:0]       ram_addr_out,
   output logic             sfs_sel_out,
   output logic [7:0]       sfs_page_out,
   output logic [7:0]       sfs_addr_out,
   output logic             bit_sel_out,
   output logic [2:0]       bit_pos_out,
   // External answers
   output logic             onchip_sel_out,
   output logic [11:0]      onchip_addr_out,
   output logic             port_cycle_out,
   output logic [15:0]      port_addr_out,
   output logic [7:0]       port_ad_low_out,
   output logic             port_ale_out,
   // Program answers
   output logic             prog_sel_out,
   output logic             prog_refused_out,
   output logic             prog_xsect_out,
   output logic [16:0]      prog_sector_out
);

   // ==========================================
   // Helpers
   function automatic logic in_range(input logic [16:0] a, input logic [16:0] lo,
                                     input logic [16:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [7:0] bank_base;
   assign bank_base = {3'b000, bank_sel_in, 3'b000};

   // ==========================================
   // Internal data decode
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ram_sel_out  <= 1'b0;
         ram_addr_out <= 8'h00;
         sfs_sel_out  <= 1'b0;
         sfs_page_out <= `PAGE_RESET;
         sfs_addr_out <= 8'h00;
         bit_sel_out  <= 1'b0;
         bit_pos_out  <= 3'h0;
      end
      else
      begin
         ram_sel_out  <= 1'b0;
         sfs_sel_out  <= 1'b0;
         bit_sel_out  <= 1'b0;
         if (reg_req_in)
         begin
            // Register operand from the selected bank
            ram_sel_out  <= 1'b1;
            ram_addr_out <= bank_base | {5'h00, reg_num_in};
         end
         else if (int_req_in && int_bitmode_in)
         begin
            // Bit address: low half maps into 0x20-0x2F, high half to the page
            bit_pos_out <= int_addr_in[2:0];
            if (!int_addr_in[7])
            begin
               ram_sel_out  <= 1'b1;
               bit_sel_out  <= 1'b1;
               ram_addr_out <= `BIT_AREA_BASE | {4'h0, int_addr_in[6:3]};
            end
            else
            begin
               sfs_sel_out  <= 1'b1;
               bit_sel_out  <= 1'b1;
               sfs_page_out <= page_sel_in;
               sfs_addr_out <= {int_addr_in[7:3], 3'b000};
            end
         end
         else if (int_req_in)
         begin
            if (int_addr_in < `UPPER_HALF_BASE || int_indirect_in)
            begin
               ram_sel_out  <= 1'b1;
               ram_addr_out <= int_addr_in;
            end
            else
            begin
               sfs_sel_out  <= 1'b1;
               sfs_page_out <= page_sel_in;
               sfs_addr_out <= int_addr_in;
            end
         end
      end
   end

   // ==========================================
   // External data decode
   logic x_off;
   always_comb
   begin
      case (mem_map_pkg::xmap_mode_t'(xmap_mode_in))
         mem_map_pkg::XMAP_ONCHIP:  x_off = 1'b0;
         mem_map_pkg::XMAP_OFFCHIP: x_off = 1'b1;
         mem_map_pkg::XMAP_SPLIT:   x_off = (x_addr_in > `ONCHIP_SPLIT_TOP);
         default:                   x_off = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         onchip_sel_out  <= 1'b0;
         onchip_addr_out <= 12'h000;
         port_cycle_out  <= 1'b0;
         port_addr_out   <= 16'h0000;
         port_ad_low_out <= 8'h00;
         port_ale_out    <= 1'b0;
      end
      else
      begin
         onchip_sel_out <= x_req_in && !x_off;
         port_cycle_out <= x_req_in && x_off;
         port_ale_out   <= x_req_in && x_off && mux_mode_in;
         if (x_req_in)
         begin
            onchip_addr_out <= 12'(x_addr_in & `ONCHIP_ADDR_MASK);
            port_addr_out   <= x_addr_in;
            // Multiplexed: low address on the shared lines; else separate
            port_ad_low_out <= mux_mode_in ? x_addr_in[7:0] : 8'h00;
         end
      end
   end

   // ==========================================
   // Program decode
   logic p_rsvd;
   logic p_x;
   assign p_rsvd = in_range(prog_addr_in, `PROG_RSVD_BASE, `PROG_RSVD_TOP);
   assign p_x    = in_range(prog_addr_in, `PROG_XSECT_BASE, `PROG_XSECT_TOP);

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         prog_sel_out     <= 1'b0;
         prog_refused_out <= 1'b0;
         prog_xsect_out   <= 1'b0;
         prog_sector_out  <= 17'h00000;
      end
      else
      begin
         prog_sel_out     <= prog_req_in && !p_rsvd && (p_x || !prog_addr_in[16]);
         prog_refused_out <= prog_req_in && (p_rsvd || (prog_addr_in[16] && !p_x));
         prog_xsect_out   <= prog_req_in && p_x;
         if (prog_req_in && prog_erase_in)
            prog_sector_out <= p_x ? (prog_addr_in & `SECTOR_X_MASK)
                                   : (prog_addr_in & `SECTOR_MAIN_MASK);
      end
   end

   // ==========================================
   // Assertions
   sfs_direct_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      int_req_in && !reg_req_in && !int_bitmode_in && !int_indirect_in && int_addr_in[7]
      |=> sfs_sel_out && !ram_sel_out)
      else $error("direct upper access not routed to special function space");
   ram_indirect_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      int_req_in && !reg_req_in && !int_bitmode_in && int_indirect_in
      |=> ram_sel_out && ram_addr_out == $past(int_addr_in))
      else $error("indirect access not routed to RAM");
   page_follow_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      sfs_sel_out |-> sfs_page_out == $past(page_sel_in))
      else $error("page not taken from active page");
   low_direct_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      int_req_in && !reg_req_in && !int_bitmode_in && !int_addr_in[7] |=> !sfs_sel_out)
      else $error("low direct access reached special function space");
   bank_addr_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      reg_req_in |=> ram_addr_out <= 8'h1F && ram_addr_out[4:3] == $past(bank_sel_in))
      else $error("register operand outside selected bank");
   bit_area_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      bit_sel_out && ram_sel_out |-> ram_addr_out >= 8'h20 && ram_addr_out <= 8'h2F)
      else $error("bit access outside bit area");
   split_low_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      x_req_in && xmap_mode_in == 2'b01 && x_addr_in < 16'h1000
      |=> onchip_sel_out && !port_cycle_out)
      else $error("split low address started a port cycle");
   onchip_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      x_req_in && xmap_mode_in == 2'b00 |=> onchip_sel_out && onchip_addr_out == $past(x_addr_in[11:0]))
      else $error("on-chip alias wrong");
   offchip_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      x_req_in && xmap_mode_in == 2'b10 |=> port_cycle_out && !onchip_sel_out)
      else $error("off-chip mode did not start port cycle");
   rsvd_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      prog_req_in && prog_addr_in >= 17'h0EE00 && prog_addr_in <= 17'h0FFFF
      |=> prog_refused_out && !prog_sel_out)
      else $error("reserved program address accepted");

   split_c:  cover property (@(posedge ref_clk_in) x_req_in && xmap_mode_in == 2'b01 ##1 port_cycle_out);
   sfs_c:    cover property (@(posedge ref_clk_in) sfs_sel_out && sfs_page_out != 8'h00);
   xsect_c:  cover property (@(posedge ref_clk_in) prog_xsect_out);
   bit_c:    cover property (@(posedge ref_clk_in) bit_sel_out && ram_sel_out);

endmodule // mem_map

// [ext_mem_model.sv]
// Behavioural off-chip memory on the external memory port
`timescale 1ns/1ps
module ext_mem_model
(
   input  wire logic        clk_in,
   input  wire logic        cycle_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [7:0]  ad_low_in,
   input  wire logic        ale_in,
   input  wire logic        mux_in,
   output logic      [15:0] seen_out
);
   // Multiplexed: low byte from the shared lines, only while ALE is up; else the whole address
   always_ff @(negedge clk_in)
   begin
      if (cycle_in && mux_in && ale_in)
      begin
         seen_out <= {addr_in[15:8], ad_low_in};
      end
      else if (cycle_in && !mux_in)
      begin
         seen_out <= addr_in;
      end
   end
endmodule // ext_mem_model

// [tb_data_memory_address_map.sv]
// Self-checking bench for the memory address decoder
`timescale 1ns/1ps
module tb_data_memory_address_map;
   // Note kinds: 0 ram, 1 sfs, 2 bit, 3 onchip, 4 port, 5 prog, 6 refused
   typedef struct {int k; logic [16:0] a; logic [7:0] b; logic f;} note_t;
   note_t notes[$];
   int n_errors = 0, checks = 0, cyc = 0;
   logic ref_clk_in = 0, resetn_in = 0, int_req_in = 0, int_indirect_in = 0;
   logic int_bitmode_in = 0, reg_req_in = 0, x_req_in = 0, mux_mode_in = 0;
   logic prog_req_in = 0, prog_erase_in = 0;
   logic [7:0] int_addr_in = 0, page_sel_in = 0;
   logic [2:0] reg_num_in = 0;
   logic [1:0] bank_sel_in = 0, xmap_mode_in = 0;
   logic [15:0] x_addr_in = 0;
   logic [16:0] prog_addr_in = 0;
   logic ram_sel_out, sfs_sel_out, bit_sel_out, onchip_sel_out, port_cycle_out;
   logic port_ale_out, prog_sel_out, prog_refused_out, prog_xsect_out;
   logic [7:0] ram_addr_out, sfs_page_out, sfs_addr_out, port_ad_low_out;
   logic [2:0] bit_pos_out;
   logic [11:0] onchip_addr_out;
   logic [15:0] port_addr_out, seen;
   logic mux_q = 0;
   logic [16:0] prog_sector_out;
   logic [16:0] pa[7] = '{17'h0EDFF, 17'h0EE00, 17'h0FFFF, 17'h10000, 17'h1007F, 17'h10080,
                          17'h001FF};
   mem_map DUT (.ref_clk_in, .resetn_in, .int_req_in, .int_indirect_in, .int_bitmode_in,
      .int_addr_in, .reg_req_in, .reg_num_in, .bank_sel_in, .page_sel_in, .x_req_in,
      .x_addr_in, .xmap_mode_in, .mux_mode_in, .prog_req_in, .prog_erase_in, .prog_addr_in,
      .ram_sel_out, .ram_addr_out, .sfs_sel_out, .sfs_page_out, .sfs_addr_out, .bit_sel_out,
      .bit_pos_out, .onchip_sel_out, .onchip_addr_out, .port_cycle_out, .port_addr_out,
      .port_ad_low_out, .port_ale_out, .prog_sel_out, .prog_refused_out, .prog_xsect_out,
      .prog_sector_out);
   ext_mem_model mem (.clk_in(ref_clk_in), .cycle_in(port_cycle_out), .addr_in(port_addr_out),
      .ad_low_in(port_ad_low_out), .ale_in(port_ale_out), .mux_in(mux_q),
      .seen_out(seen));
   // Port arrangement of the cycle in flight
   always @(posedge ref_clk_in) mux_q <= mux_mode_in;
   initial
   begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   // ==========================================
   // Drivers
   task go(input logic i, r, x, p);
      @(posedge ref_clk_in);
      #1;
      {int_req_in, reg_req_in, x_req_in, prog_req_in} = {i, r, x, p};
   endtask
   task note(input int k, input logic [16:0] a, input logic [7:0] b, input logic f);
      notes.push_back('{k, a, b, f});
   endtask
   task int_acc(input logic ind, bm, input logic [7:0] ad, pg);
      go(1, 0, 0, 0);
      {int_indirect_in, int_bitmode_in, int_addr_in, page_sel_in} = {ind, bm, ad, pg};
      if (bm) note(2, ad, pg, 0);
      else if (ad >= 8'h80 && !ind) note(1, ad, pg, 0);
      else note(0, ad, 0, 0);
   endtask
   task reg_acc(input logic [1:0] bk, input logic [2:0] r);
      go(0, 1, 0, 0);
      {bank_sel_in, reg_num_in} = {bk, r};
      note(0, {bk, r}, 0, 0);
   endtask
   task x_acc(input logic [1:0] m, input logic mx, input logic [15:0] ad);
      go(0, 0, 1, 0);
      {xmap_mode_in, mux_mode_in, x_addr_in} = {m, mx, ad};
      if (m == 2'h2 || (m == 2'h1 && ad > 16'h0FFF)) note(4, ad, 0, mx);
      else note(3, ad, 0, 0);
   endtask
   task p_acc(input logic er, input logic [16:0] ad);
      go(0, 0, 0, 1);
      {prog_erase_in, prog_addr_in} = {er, ad};
      if ((ad >= 17'h0EE00 && ad <= 17'h0FFFF) || ad > 17'h1007F) note(6, ad, 0, 0);
      else if (ad[16]) note(5, ad & 17'h1FF80, er, 1);
      else note(5, ad & 17'h1FE00, er, 0);
   endtask
   // ==========================================
   // Checking
   task chk(input logic [16:0] g, e);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task check_int(input note_t n);
      if (n.k == 2)
      begin
         chk({bit_sel_out, ram_sel_out, bit_pos_out}, {1'b1, ~n.a[7], n.a[2:0]});
         if (n.a[7])
            chk({sfs_sel_out, sfs_page_out, sfs_addr_out},
                {1'b1, n.b, n.a[7:3], 3'b000});
         else
            chk({sfs_sel_out, ram_addr_out}, {1'b0, 4'h2, n.a[6:3]});
      end
      else if (n.k == 1)
      begin
         chk({ram_sel_out, sfs_sel_out, sfs_addr_out}, {2'b01, n.a[7:0]});
         chk(sfs_page_out, n.b);
      end
      else chk({ram_sel_out, sfs_sel_out, ram_addr_out}, {2'b10, n.a[7:0]});
   endtask
   task check_ext(input note_t n);
      if (n.k == 3)
         chk({onchip_sel_out, port_cycle_out, onchip_addr_out}, {2'b10, n.a[11:0]});
      else
      begin
         chk({onchip_sel_out, port_cycle_out, port_ale_out}, {2'b01, n.f});
         chk(port_addr_out, n.a[15:0]);
         chk(port_ad_low_out, n.f ? n.a[7:0] : 8'h00);
         chk(seen, n.a[15:0]);
      end
   endtask
   task check_prog(input note_t n);
      if (n.k == 6) chk({prog_sel_out, prog_refused_out}, 2'b01);
      else chk({prog_sel_out, prog_refused_out, prog_xsect_out}, {2'b10, n.f});
      if (n.k == 5 && n.b[0]) chk(prog_sector_out, n.a);
   endtask
   always
   begin
      @(posedge ref_clk_in);
      #6;
      if (ram_sel_out | sfs_sel_out | bit_sel_out | onchip_sel_out | port_cycle_out
          | prog_sel_out | prog_refused_out)
      begin
         if (notes.size() == 0) chk(17'h00001, 17'h00000);
         else
         begin
            automatic note_t n = notes.pop_front();
            if (n.k < 3) check_int(n);
            else if (n.k < 5) check_ext(n);
            else check_prog(n);
         end
      end
   end
   task close_out;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_errors++;
         close_out;
      end
   end
   // ==========================================
   // Stimulus
   initial
   begin
      void'($urandom(87667));
      repeat (4) @(posedge ref_clk_in);
      #1 resetn_in = 1;
      int_acc(0, 0, 8'h7F, 8'h05);
      int_acc(0, 0, 8'h80, 8'h05);
      int_acc(1, 0, 8'h80, 8'hFF);
      int_acc(0, 0, 8'h2F, 8'h00);
      int_acc(1, 1, 8'h7F, 8'h00);
      for (int b = 0; b < 4; b++) reg_acc(b, 3'h7);
      for (int m = 0; m < 8; m++)
      begin
         x_acc(m[2:1], m[0], 16'h0FFF);
         x_acc(m[2:1], m[0], 16'h1000);
         x_acc(m[2:1], m[0], 16'hF123);
      end
      foreach (pa[i]) p_acc(i[0], pa[i]);
      repeat (200)
      begin
         case ($urandom % 4)
            0: int_acc($urandom, $urandom, $urandom, $urandom);
            1: reg_acc($urandom, $urandom);
            2: x_acc($urandom, $urandom, $urandom);
            default: p_acc($urandom, $urandom_range(0, 17'h1FFFF));
         endcase
      end
      go(0, 0, 0, 0);
      repeat (3) @(posedge ref_clk_in);
      chk(17'(notes.size()), 17'h00000);
      close_out;
   end
endmodule // tb_data_memory_address_map
